// File: common/hrp_pkg.sv
// package for the host register port: widths, bit positions, reset values, state codes
// assumes an 8-bit parallel host bus and a register map held by logic outside this port
package hrp_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          IRQ_N         = 8;
  localparam int          TEST_SEL_BIT  = 7;
  localparam logic [6:0]  IRQ_ACK_ADDR  = 7'h00;
  localparam logic [7:0]  ADDR_RST      = 8'h00;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [7:0]  IRQ_RST       = 8'h00;
  localparam logic [1:0]  SYNC_RST      = 2'h3;

  typedef enum logic [1:0] {
    HRP_IDLE  = 2'b00,
    HRP_READ  = 2'b01,
    HRP_WRITE = 2'b10
  } hrp_state_e;
endpackage

// File: common/hrp_strobe_if.sv
// strobe signals between the pin front end and the access decoder
// assumes all signals are already synchronised to core_clk
`timescale 1ns/10ps
interface hrp_strobe_if;
  logic bus_style;
  logic cs_n;
  logic rd_n_e;
  logic wr_n_rw;
  logic rd_active;
  logic wr_pulse;
  logic rd_done;

  modport decode (
    input  bus_style,
    input  cs_n,
    input  rd_n_e,
    input  wr_n_rw,
    output rd_active,
    output wr_pulse,
    output rd_done
  );
  modport core (
    output bus_style,
    output cs_n,
    output rd_n_e,
    output wr_n_rw,
    input  rd_active,
    input  wr_pulse,
    input  rd_done
  );
endinterface

// File: rtl/hrp_access_decode.sv
// access decoder: turns synchronised strobes into read level and write / read-end pulses
// assumes strobes pass through the synchroniser in the top before arriving here
`timescale 1ns/10ps
module hrp_access_decode
  import hrp_pkg::*;
(
  input wire logic    core_clk,
  input wire logic    rst_n,
  hrp_strobe_if.decode sb
);
  hrp_state_e state_q;
  hrp_state_e state_d;
  logic       rd_req;
  logic       wr_req;

  // strobe style: enable plus rw select, or separate read and write strobes
  always_comb begin
    if (sb.bus_style) begin
      rd_req = !sb.cs_n && !sb.rd_n_e;
      wr_req = !sb.cs_n && !sb.wr_n_rw;
    end else begin
      rd_req = !sb.cs_n && sb.rd_n_e && sb.wr_n_rw;
      wr_req = !sb.cs_n && sb.rd_n_e && !sb.wr_n_rw;
    end
  end

  always_comb begin
    state_d      = state_q;
    sb.wr_pulse  = 1'b0;
    sb.rd_done   = 1'b0;
    case (state_q)
      HRP_IDLE: begin
        if (rd_req) begin
          state_d = HRP_READ;
        end else if (wr_req) begin
          state_d = HRP_WRITE;
        end
      end
      HRP_READ: begin
        if (!rd_req) begin
          state_d    = HRP_IDLE;
          sb.rd_done = 1'b1;
        end
      end
      HRP_WRITE: begin
        // strobe release is the capture point: rising write strobe or falling enable
        if (!wr_req) begin
          state_d     = HRP_IDLE;
          sb.wr_pulse = 1'b1;
        end
      end
      default: begin
        state_d = HRP_IDLE;
      end
    endcase
  end

  assign sb.rd_active = (state_q == HRP_READ);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HRP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
endmodule

// File: rtl/hrp_host_port.sv
// host register port control: pin synchronisers, address latch, data drive, interrupt line
// assumes the register map sits on the user side and answers reads within one cycle
`timescale 1ns/10ps
module hrp_host_port
  import hrp_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr_pin,
  input  wire logic              ale_pin,
  input  wire logic              chip_sel_low,
  input  wire logic              read_strobe_low,
  input  wire logic              write_strobe_low,
  input  wire logic              bus_style_select,
  input  wire logic [DATA_W-1:0] data_in,
  output      logic [DATA_W-1:0] data_out,
  output      logic              data_oe,
  output      logic              irq_out_low_o,
  output      logic              irq_out_low_oe,
  input  wire logic [IRQ_N-1:0]  irq_event,
  output      logic [IRQ_N-1:0]  irq_pending,
  output      logic [6:0]        reg_addr,
  output      logic              test_space_select,
  output      logic              reg_wr,
  output      logic [DATA_W-1:0] reg_wr_data,
  output      logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_rd_data
);
  // two-stage synchronisers, three stages on data: each stage feeds only the next
  logic [ADDR_W-1:0] addr_s1_q;
  logic [ADDR_W-1:0] addr_s2_q;
  logic [DATA_W-1:0] data_s1_q;
  logic [DATA_W-1:0] data_s2_q;
  logic [DATA_W-1:0] data_s3_q;
  logic [1:0]        ale_q;
  logic [1:0]        cs_q;
  logic [1:0]        rd_q;
  logic [1:0]        wr_q;
  logic [1:0]        style_q;
  logic [1:0]        ale_d;
  logic [1:0]        cs_d;
  logic [1:0]        rd_d;
  logic [1:0]        wr_d;
  logic [1:0]        style_d;

  // latch, data and interrupt state
  logic [ADDR_W-1:0] addr_lat_q;
  logic [ADDR_W-1:0] addr_lat_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic              doe_q;
  logic              doe_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic              wr_q1;
  logic              wr_d1;
  logic              rd_q1;
  logic              rd_d1;
  logic [IRQ_N-1:0]  pend_q;
  logic [IRQ_N-1:0]  pend_d;
  logic              irq_q;
  logic              irq_d;
  logic              ack;

  hrp_strobe_if sb ();

  function automatic logic is_ack_access(input logic [ADDR_W-1:0] a);
    is_ack_access = !a[TEST_SEL_BIT] && (a[6:0] == IRQ_ACK_ADDR);
  endfunction

  // strobe synchroniser next values: stage one feeds only stage two
  always_comb begin
    ale_d   = {ale_q[0], ale_pin};
    cs_d    = {cs_q[0], chip_sel_low};
    rd_d    = {rd_q[0], read_strobe_low};
    wr_d    = {wr_q[0], write_strobe_low};
    style_d = {style_q[0], bus_style_select};
  end

  // address and data are sampled bit by bit, so the host must hold them steady
  // across the synchroniser delay; a moving bus could land as a mixed word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_s1_q <= ADDR_RST;
      addr_s2_q <= ADDR_RST;
      data_s1_q <= DATA_RST;
      data_s2_q <= DATA_RST;
      data_s3_q <= DATA_RST;
    end else begin
      addr_s1_q <= addr_pin;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
      data_s3_q <= data_s2_q;
    end
  end

  // strobes reset to their idle high level, so leaving reset shows no access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_q   <= SYNC_RST;
      cs_q    <= SYNC_RST;
      rd_q    <= SYNC_RST;
      wr_q    <= SYNC_RST;
      style_q <= SYNC_RST;
    end else begin
      ale_q   <= ale_d;
      cs_q    <= cs_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      style_q <= style_d;
    end
  end

  assign sb.bus_style = style_q[1];
  assign sb.cs_n      = cs_q[1];
  assign sb.rd_n_e    = rd_q[1];
  assign sb.wr_n_rw   = wr_q[1];

  hrp_access_decode u_decode (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sb       (sb)
  );

  // the host keeps chip select low across the access, so a release ends it cleanly
  assign ack = sb.rd_done && is_ack_access(addr_lat_q);

  // address latch group
  always_comb begin
    // transparent while latch enable high, holding while low
    addr_lat_d = ale_q[1] ? addr_s2_q : addr_lat_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_lat_q <= ADDR_RST;
    end else begin
      addr_lat_q <= addr_lat_d;
    end
  end

  // read group: pin drive, read data and the read-start pulse
  always_comb begin
    doe_d  = sb.rd_active;
    dout_d = sb.rd_active ? reg_rd_data : dout_q;
    // doe_q is rd_active one cycle late, so the pulse fires once per access
    rd_d1  = sb.rd_active && !doe_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doe_q  <= 1'b0;
      dout_q <= DATA_RST;
      rd_q1  <= 1'b0;
    end else begin
      doe_q  <= doe_d;
      dout_q <= dout_d;
      rd_q1  <= rd_d1;
    end
  end

  // write group
  always_comb begin
    // data a cycle older than the strobe release, still stable within the access
    wdata_d = sb.wr_pulse ? data_s3_q : wdata_q;
    wr_d1   = sb.wr_pulse;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q <= DATA_RST;
      wr_q1   <= 1'b0;
    end else begin
      wdata_q <= wdata_d;
      wr_q1   <= wr_d1;
    end
  end

  // interrupt group
  always_comb begin
    // a new event in the acknowledge cycle is kept: set wins over clear
    pend_d = (ack ? IRQ_RST : pend_q) | irq_event;
    irq_d  = |pend_d;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= IRQ_RST;
      irq_q  <= 1'b0;
    end else begin
      pend_q <= pend_d;
      irq_q  <= irq_d;
    end
  end

  assign reg_addr          = addr_lat_q[6:0];
  assign test_space_select = addr_lat_q[TEST_SEL_BIT];
  assign reg_wr            = wr_q1;
  assign reg_wr_data       = wdata_q;
  assign reg_rd            = rd_q1;
  assign data_out          = dout_q;
  assign data_oe           = doe_q;
  assign irq_pending       = pend_q;
  // open drain: drive a constant low only while pending, release otherwise
  assign irq_out_low_o     = 1'b0;
  assign irq_out_low_oe    = irq_q;
endmodule

// File: testbench/hrp_host_port_props.sv
// checker for the host port: read, write, address latch and interrupt timing
// assumes bind onto hrp_host_port; pins pass two sync flops inside
`timescale 1ns/10ps
module hrp_port_props
  import hrp_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic              ale_pin,
  input wire logic              chip_sel_low,
  input wire logic              read_strobe_low,
  input wire logic              write_strobe_low,
  input wire logic              bus_style_select,
  input wire logic [IRQ_N-1:0]  irq_event,
  input wire logic              irq_out_low_o,
  input wire logic              irq_out_low_oe,
  input wire logic              data_oe,
  input wire logic              reg_rd,
  input wire logic              reg_wr,
  input wire logic [6:0]        reg_addr,
  input wire logic              test_space_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire sel = bus_style_select;
  wire rd_c = !chip_sel_low && (sel ? !read_strobe_low : read_strobe_low && write_strobe_low);
  wire wr_c = !chip_sel_low && (sel ? !write_strobe_low : read_strobe_low && !write_strobe_low);
  sequence s_rd_start; !rd_c ##1 rd_c; endsequence
  sequence s_wr_end; wr_c ##1 !wr_c; endsequence
  a_od_value: assert property (irq_out_low_o == 1'b0)
    else $error("irq pin value not low");
  a_irq_raise: assert property (|irq_event |=> irq_out_low_oe)
    else $error("irq not raised");
  a_irq_ack_addr: assert property ($fell(irq_out_low_oe) |->
    !test_space_select && reg_addr == IRQ_ACK_ADDR)
    else $error("irq released without ack");
  a_read_drive: assert property (s_rd_start |-> ##4 (data_oe && reg_rd))
    else $error("read not driven");
  a_read_cause: assert property ($rose(data_oe) |-> $past(rd_c, 4))
    else $error("data driven without read");
  a_write_pulse: assert property (s_wr_end |-> ##3 reg_wr ##1 !reg_wr)
    else $error("write pulse wrong");
  a_addr_follow: assert property ($past(ale_pin, 3) && $past(rst_n, 4) |->
    {test_space_select, reg_addr} == $past(addr_pin, 3))
    else $error("address not followed");
  a_addr_hold: assert property (!$past(ale_pin, 3) && $past(rst_n, 4) |->
    $stable({test_space_select, reg_addr}))
    else $error("address not held");
endmodule
bind hrp_host_port hrp_port_props hrp_port_props_inst (.core_clk, .rst_n, .addr_pin, .ale_pin,
  .chip_sel_low, .read_strobe_low, .write_strobe_low, .bus_style_select, .irq_event,
  .irq_out_low_o, .irq_out_low_oe, .data_oe, .reg_rd, .reg_wr, .reg_addr, .test_space_select);

// File: testbench/hrp_host_model.sv
// host processor model: address, latch enable, strobes and the shared data bus
// assumes pins change on the falling edge and reads settle within 7 cycles
`timescale 1ns/10ps
module hrp_host_model
  import hrp_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe,
  output      logic [ADDR_W-1:0] addr_pin,
  output      logic              ale_pin,
  output      logic              chip_sel_low,
  output      logic              read_strobe_low,
  output      logic              write_strobe_low,
  output      logic              bus_style_select,
  output wire logic [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] hdata;
  logic [DATA_W-1:0] last_q;
  logic              hdrive = 1'b0;
  // released bus shows the inverse of its last level, never a stale copy
  assign data_in = data_oe ? data_out : (hdrive ? hdata : ~last_q);
  always_ff @(posedge core_clk) last_q <= data_in;
  // pins idle before the first access: separate strobes, nothing selected
  initial begin
    addr_pin         = 8'h00;
    ale_pin          = 1'b1;
    chip_sel_low     = 1'b1;
    read_strobe_low  = 1'b1;
    write_strobe_low = 1'b1;
    bus_style_select = 1'b1;
  end
  task automatic acc(input bit rd, input bit style, input bit mux, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk);
    bus_style_select = style;
    read_strobe_low = style;
    write_strobe_low = 1'b1;
    addr_pin = a;
    ale_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    if (mux) begin
      ale_pin = 1'b0;
      addr_pin = ~a;
    end
    chip_sel_low = 1'b0;
    write_strobe_low = style | rd;
    hdata = d;
    hdrive = !rd;
    @(negedge core_clk);
    if (!style) read_strobe_low = 1'b1;
    else if (rd) read_strobe_low = 1'b0;
    else write_strobe_low = 1'b0;
    repeat (7) @(negedge core_clk);
    q = data_in;
    read_strobe_low = style;
    if (style) write_strobe_low = 1'b1;
    repeat (3) @(negedge core_clk);
    chip_sel_low = 1'b1;
    hdrive = 1'b0;
    ale_pin = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
endmodule

// File: testbench/host_register_port_control_test.sv
// top bench: random writes and reads in both bus styles, interrupts, reset in mid-run
// assumes the host model and the bound checker; expectations come from local functions
`timescale 1ns/10ps
module host_register_port_control_test;
  import hrp_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr_pin, data_in, data_out, irq_event, reg_wr_data, reg_rd_data, a, d, q, wd, wa;
  logic [6:0] reg_addr;
  logic [7:0] irq_pending;
  logic       ale_pin, chip_sel_low, read_strobe_low, write_strobe_low, bus_style_select;
  logic       data_oe, irq_out_low_o, irq_out_low_oe, test_space_select, reg_wr;
  logic [31:0] seed;
  int         err_count = 0, n_tests = 0, n_wr = 0, k;
  wire        irq_pin = irq_out_low_oe ? irq_out_low_o : 1'b1;
  always #10 core_clk = ~core_clk;
  hrp_host_port hrp_host_port_inst (.core_clk, .rst_n, .addr_pin, .ale_pin, .chip_sel_low,
    .read_strobe_low, .write_strobe_low, .bus_style_select, .data_in, .data_out, .data_oe,
    .irq_out_low_o, .irq_out_low_oe, .irq_event, .irq_pending, .reg_addr, .test_space_select,
    .reg_wr, .reg_wr_data, .reg_rd(), .reg_rd_data);
  hrp_host_model hrp_host_model_inst (.core_clk, .data_out, .data_oe, .addr_pin, .ale_pin,
    .chip_sel_low, .read_strobe_low, .write_strobe_low, .bus_style_select, .data_in);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    return {x[6:0], x[7]} ^ 8'hA5;
  endfunction
  always @(negedge core_clk) reg_rd_data <= exp_rd({test_space_select, reg_addr});
  always @(negedge core_clk)
    if (reg_wr === 1'b1) begin
      n_wr++;
      wd = reg_wr_data;
      wa = {test_space_select, reg_addr};
    end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge core_clk);
    err_count++;
    finish_test();
  end
  initial begin
    seed = 32'd99844;
    irq_event = 8'h00;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      a = (i < 3) ? {i[0], {7{i[1]}}} : seed[7:0];
      d = seed[15:8];
      k = n_wr;
      hrp_host_model_inst.acc(1'b0, i[0], i[1], a, d, q);
      check("write count", 8'(k + 1), 8'(n_wr));
      check("write data", d, wd);
      check("write addr", a, wa);
      hrp_host_model_inst.acc(1'b1, i[0], i[2], a, 8'h00, q);
      check("read data", exp_rd(a), q);
    end
    $display("test write_read done");
    seed = lfsr(seed);
    d = seed[7:0] | 8'h01;
    irq_event = d;
    @(negedge core_clk);
    irq_event = 8'h00;
    @(negedge core_clk);
    check("irq pin", 8'h00, {7'h0, irq_pin});
    check("irq pending", d, irq_pending);
    hrp_host_model_inst.acc(1'b1, 1'b1, 1'b0, 8'h80, 8'h00, q);
    check("irq after test read", 8'h00, {7'h0, irq_pin});
    check("pending after test read", d, irq_pending);
    hrp_host_model_inst.acc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, q);
    check("irq after ack", 8'h01, {7'h0, irq_pin});
    check("pending after ack", 8'h00, irq_pending);
    $display("test irq done");
    irq_event = 8'h01;
    @(negedge core_clk);
    irq_event = 8'h00;
    #5 rst_n = 1'b0;
    #1 check("irq in reset", 8'h01, {7'h0, irq_pin});
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    check("pending after reset", 8'h00, irq_pending);
    $display("test reset done");
    finish_test();
  end
endmodule
